/* File: sim/ccl_checker_props.sv */
// Port-level concurrent checks for the confidence limit checker
`timescale 1ns/1ps
`default_nettype none
module ccl_checker_props (
    input wire clk_sys,
    input wire srst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire page_start,
    input wire page_conf,
    input wire [7:0] page_words,
    input wire check_valid
);
    logic ps_d;
    logic prev_conf;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    // Remembers whether the previous page carried confidence
    always @(posedge clk_sys) begin
        if (srst) begin
            ps_d <= 1'b0;
            prev_conf <= 1'b0;
        end else begin
            ps_d <= page_start;
            if (ps_d)
                prev_conf <= page_conf;
        end
    end
    sequence s_access;
        psel && penable;
    endsequence
    sequence s_bad_addr;
        s_access ##0 (paddr > 8'h48 || paddr[1:0] != 2'b00);
    endsequence
    a_ready_now: assert property (pready == (psel && penable)) else $error("pready wrong");
    a_err_unmapped: assert property (s_bad_addr |-> pslverr) else $error("no error on hole");
    a_rd_hole_zero: assert property (s_bad_addr ##0 !pwrite |-> prdata == 32'h0)
        else $error("hole read not zero");
    a_err_mapped: assert property (s_access ##0 (paddr <= 8'h48 && paddr[1:0] == 2'b00) |-> !pslverr)
        else $error("error on mapped address");
    a_page_len: assert property (page_words == (page_conf ? 8'hF8 : 8'h18))
        else $error("page length wrong");
    a_page_hold: assert property (!page_start |=> $stable(page_conf) && $stable(page_words))
        else $error("page info moved");
    a_alt_pages: assert property (ps_d && !check_valid && prev_conf |-> !page_conf)
        else $error("two confidence pages in a row");
    a_reset_state: assert property ($fell(srst) |-> check_valid && !page_conf)
        else $error("bad state after reset");
endmodule // ccl_checker_props
bind ccl_checker ccl_checker_props u_ccl_checker_props (
    .clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .page_start(page_start), .page_conf(page_conf), .page_words(page_words),
    .check_valid(check_valid)
);
`default_nettype wire

/* File: sim/ccl_meas_src.sv */
// Measurement source model driving confidence samples
`timescale 1ns/1ps
`default_nettype none
module ccl_meas_src (
    input wire logic clk_sys,
    output logic meas_valid,
    output logic [5:0] meas_chan,
    output logic [3:0] meas_src,
    output logic [15:0] meas_value
);
    // Idle lines start at zero, then show the inverse after each send so stale values never match
    initial begin
        meas_valid = 1'b0;
        meas_chan = 6'h00;
        meas_src = 4'h0;
        meas_value = 16'h0000;
    end
    task automatic send(input logic [5:0] c, input logic [3:0] s, input logic [15:0] v);
        @(posedge clk_sys);
        meas_valid <= 1'b1;
        meas_chan <= c;
        meas_src <= s;
        meas_value <= v;
        @(posedge clk_sys);
        meas_valid <= 1'b0;
        meas_chan <= ~c;
        meas_src <= ~s;
        meas_value <= ~v;
    endtask
endmodule // ccl_meas_src
`default_nettype wire

/* File: sim/confidence_limit_checker_tb.sv */
// Self-checking bench for the confidence limit checker
`timescale 1ns/1ps
`default_nettype none
`include "ccl_consts.vh"
module confidence_limit_checker_tb;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic page_start = 1'b0;
    wire [31:0] prdata;
    wire pready, pslverr, page_conf, check_valid, irq, meas_valid;
    wire [7:0] page_words;
    wire [5:0] meas_chan;
    wire [3:0] meas_src;
    wire [15:0] meas_value;
    logic [31:0] rdat;
    logic rerr;
    logic [31:0] rt [3] = '{32'h7D0, 32'h3E8, 32'h1F4};
    int error_cnt = 0;
    int n_compared = 0;
    int cyc = 0;
    int nconf;
    ccl_checker u_ccl_checker (.clk_sys(clk_sys), .srst(srst), .clk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .page_start(page_start), .meas_valid(meas_valid),
        .meas_chan(meas_chan), .meas_src(meas_src), .meas_value(meas_value),
        .page_conf(page_conf), .page_words(page_words), .check_valid(check_valid), .irq(irq));
    ccl_meas_src u_ccl_meas_src (.clk_sys(clk_sys), .meas_valid(meas_valid),
        .meas_chan(meas_chan), .meas_src(meas_src), .meas_value(meas_value));
    // Clock and hang guard
    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            summarize();
        end
    end
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One APB transfer, held until pready at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rdat);
    endtask
    task automatic lim(input logic [5:0] c, input logic [3:0] s, input logic [15:0] lo,
        input logic [15:0] hi);
        wr(`CCL_OFF_LIMIT_SEL, {20'h0, s, 2'h0, c});
        wr(`CCL_OFF_LIMIT_MIN, {{16{lo[15]}}, lo});
        wr(`CCL_OFF_LIMIT_MAX, {{16{hi[15]}}, hi});
    endtask
    task automatic page();
        @(posedge clk_sys);
        page_start <= 1'b1;
        @(posedge clk_sys);
        page_start <= 1'b0;
        @(posedge clk_sys);
    endtask
    // Main sequence
    initial begin
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        rdc("page_status", `CCL_OFF_PAGE_STATUS, 32'h0000_1801);
        rdc("ctrl", `CCL_OFF_CTRL, 32'h0);
        rdc("int_status", `CCL_OFF_INT_STATUS, 32'h0);
        rdc("hole", 8'h4C, 32'h0);
        chk("hole_err", 32'h1, {31'h0, rerr});
        $display("test reset done");
        // Codes 12,3,8 unsorted; entry 3 beyond count; no diagnostic or sense codes
        wr(`CCL_OFF_SCAN_CODES_LO, 32'h0000_283C);
        wr(`CCL_OFF_SCAN_COUNT, 32'h3);
        wr(`CCL_OFF_BRIDGE_LO, 32'h0002_0020);
        wr(`CCL_OFF_RATE_HZ, 32'h64);
        wr(`CCL_OFF_CTRL, 32'h2);
        lim(6'h05, 4'h3, 16'hFFF6, 16'h000A);
        lim(6'h05, 4'h8, 16'h0000, 16'h0064);
        lim(6'h05, 4'hC, 16'h0000, 16'h0000);
        lim(6'h11, 4'h3, 16'h0000, 16'h0005);
        u_ccl_meas_src.send(6'h05, 4'h3, 16'hFFF5);
        u_ccl_meas_src.send(6'h05, 4'h8, 16'h0065);
        u_ccl_meas_src.send(6'h05, 4'hC, 16'h0000);
        u_ccl_meas_src.send(6'h05, 4'h2, 16'hFED4);
        u_ccl_meas_src.send(6'h11, 4'h3, 16'h0006);
        u_ccl_meas_src.send(6'h11, 4'h3, 16'hFFFF);
        u_ccl_meas_src.send(6'h06, 4'h3, 16'hFF9C);
        page();
        chk("page_words", 32'hF8, {24'h0, page_words});
        wr(`CCL_OFF_RESULT_SEL, 32'h05);
        rdc("detail5", `CCL_OFF_RESULT_DETAIL, 32'h0100_0008);
        wr(`CCL_OFF_RESULT_SEL, 32'h11);
        rdc("detail17", `CCL_OFF_RESULT_DETAIL, 32'h0008_0008);
        wr(`CCL_OFF_RESULT_SEL, 32'h06);
        rdc("detail6", `CCL_OFF_RESULT_DETAIL, 32'h0);
        rdc("summary0", `CCL_OFF_SUMMARY0, 32'h0020);
        rdc("summary1", `CCL_OFF_SUMMARY1, 32'h0002);
        rdc("int_status", `CCL_OFF_INT_STATUS, 32'h3);
        $display("test detail done");
        // Interrupt raised, masked, cleared
        wr(`CCL_OFF_INT_ENABLE, 32'h1);
        @(posedge clk_sys);
        chk("irq_on", 32'h1, {31'h0, irq});
        wr(`CCL_OFF_INT_ENABLE, 32'h0);
        @(posedge clk_sys);
        chk("irq_masked", 32'h0, {31'h0, irq});
        wr(`CCL_OFF_INT_CLEAR, 32'h3);
        wr(`CCL_OFF_INT_ENABLE, 32'h3);
        @(posedge clk_sys);
        chk("irq_cleared", 32'h0, {31'h0, irq});
        rdc("int_cleared", `CCL_OFF_INT_STATUS, 32'h0);
        $display("test irq done");
        // Summary-only and disabled modes
        wr(`CCL_OFF_CTRL, 32'h1);
        u_ccl_meas_src.send(6'h05, 4'h3, 16'hFFF5);
        page();
        wr(`CCL_OFF_RESULT_SEL, 32'h05);
        rdc("detail_m1", `CCL_OFF_RESULT_DETAIL, 32'h0);
        rdc("summary_m1", `CCL_OFF_SUMMARY0, 32'h0020);
        rdc("summary1_m1", `CCL_OFF_SUMMARY1, 32'h0);
        wr(`CCL_OFF_CTRL, 32'h0);
        page();
        chk("conf_m0", 32'h0, {31'h0, page_conf});
        $display("test modes done");
        // Sample rate ladder: 2000, 1000, 500 Hz
        wr(`CCL_OFF_CTRL, 32'h2);
        for (int i = 0; i < 3; i++) begin
            wr(`CCL_OFF_RATE_HZ, rt[i]);
            apb(1'b0, `CCL_OFF_PAGE_STATUS, 32'h0);
            chk("check_valid", (i == 2) ? 32'h1 : 32'h0, {31'h0, rdat[0]});
            nconf = 0;
            repeat (4) begin
                page();
                nconf += (page_conf === 1'b1) ? 1 : 0;
            end
            chk("conf_pages", i * 2, nconf);
        end
        $display("test rates done");
        wr(`CCL_OFF_RATE_HZ, 32'h64);
        wr(`CCL_OFF_SCAN_COUNT, 32'h0);
        page();
        chk("conf_empty", 32'h0, {31'h0, page_conf});
        chk("words_empty", 32'h18, {24'h0, page_words});
        $display("test empty list done");
        summarize();
    end
endmodule // confidence_limit_checker_tb
`default_nettype wire

/* File: verilog/ccl_checker.v */
// Confidence limit checker with APB register file and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "ccl_consts.vh"

module ccl_checker #(
    parameter NUM_CHAN = 48,
    parameter NUM_SRC = 13,
    parameter VAL_W = 16
) (
    input wire clk_sys,
    input wire srst,
    input wire clk_en,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output reg pslverr,
    input wire page_start,
    input wire meas_valid,
    input wire [5:0] meas_chan,
    input wire [3:0] meas_src,
    input wire [VAL_W-1:0] meas_value,
    output reg page_conf,
    output reg [7:0] page_words,
    output wire check_valid,
    output wire irq
);
    // ****************************************
    // Configuration registers
    // ****************************************
    reg [1:0] mode;
    reg [3:0] scan_source_count;
    reg [31:0] codes_lo;
    reg [19:0] codes_hi;
    reg [47:0] bridge_mask;
    reg [31:0] rate_hz;
    reg [5:0] sel_chan;
    reg [3:0] sel_src;
    reg [5:0] res_chan;
    reg [1:0] int_status;
    reg [1:0] int_enable;

    // Limit tables, one entry per channel and source
    reg [VAL_W-1:0] lim_min [0:NUM_CHAN*NUM_SRC-1];
    reg [VAL_W-1:0] lim_max [0:NUM_CHAN*NUM_SRC-1];
    // Detailed flags, two banks of 64 slots addressed {bank, chan}: one filling, one published
    reg [31:0] det_mem [0:127];
    reg [47:0] vld0;
    reg [47:0] vld1;
    reg bank;
    reg [47:0] sum_acc;
    reg [47:0] sum_pub;
    reg alt;

    // ****************************************
    // Source enable mask from the scan list
    // ****************************************
    reg [15:0] src_mask;
    reg [51:0] all_codes;
    reg [3:0] code_k;
    integer k;
    always @* begin
        all_codes = {codes_hi, codes_lo};
        src_mask = 16'h0000;
        code_k = 4'h0;
        for (k = 0; k < 13; k = k + 1) begin
            code_k = all_codes[4*k +: 4];
            // Only the first count entries count; zero count leaves mask empty
            if (k < scan_source_count && code_k < NUM_SRC)
                src_mask[code_k] = 1'b1;
        end
    end

    // Table index for channel and source
    function [9:0] tbl_idx;
        input [5:0] c;
        input [3:0] s;
        begin
            tbl_idx = ({4'h0, c} << 3) + ({4'h0, c} << 2) + {4'h0, c} + {6'h00, s};
        end
    endfunction

    // Collection gated by mode and rate
    wire collect = (mode != `CCL_MODE_DISABLE) && check_valid;
    assign check_valid = (rate_hz < `CCL_CHECK_RATE_LIMIT_HZ);

    // ****************************************
    // Measurement compare path
    // ****************************************
    wire [9:0] m_idx = tbl_idx(meas_chan, meas_src);
    wire signed [VAL_W-1:0] m_val = meas_value;
    wire signed [VAL_W-1:0] m_min = lim_min[m_idx];
    wire signed [VAL_W-1:0] m_max = lim_max[m_idx];
    wire m_take = meas_valid && collect && meas_chan < NUM_CHAN && meas_src < NUM_SRC
        && bridge_mask[meas_chan] && src_mask[meas_src];
    wire m_low = m_val < m_min;
    wire m_high = m_val > m_max;
    wire [6:0] w_addr = {~bank, meas_chan};
    wire w_vld = bank ? vld0[meas_chan] : vld1[meas_chan];
    wire [31:0] w_old = w_vld ? det_mem[w_addr] : 32'h0000_0000;
    reg [31:0] w_new;
    // Fixed bit per source, independent of list order
    always @* begin
        w_new = w_old;
        w_new[meas_src] = w_old[meas_src] | m_low;
        w_new[`CCL_MAX_FLAG_LSB + meas_src] = w_old[`CCL_MAX_FLAG_LSB + meas_src] | m_high;
    end

    // Page decision: throttle confidence to at most half of 1 kHz pages
    wire attach = (mode != `CCL_MODE_DISABLE) && (scan_source_count != 4'h0)
        && (rate_hz <= `CCL_CHECK_RATE_LIMIT_HZ)
        && (rate_hz <= `CCL_CONF_RATE_MAX_HZ || alt);

    // ****************************************
    // APB decode
    // ****************************************
    wire setup = psel && !penable;
    wire wr_acc = psel && penable && pwrite;
    assign pready = psel && penable;
    wire [9:0] s_idx = tbl_idx(sel_chan, sel_src);
    wire [6:0] r_addr = {bank, res_chan};
    wire r_vld = bank ? vld1[res_chan] : vld0[res_chan];
    reg [31:0] rd_mux;
    reg rd_err;
    // Read mux, registered during setup
    always @* begin
        rd_mux = 32'h0000_0000;
        rd_err = 1'b0;
        case (paddr)
            `CCL_OFF_CTRL: rd_mux = {30'h0, mode};
            `CCL_OFF_SCAN_COUNT: rd_mux = {28'h0, scan_source_count};
            `CCL_OFF_SCAN_CODES_LO: rd_mux = codes_lo;
            `CCL_OFF_SCAN_CODES_HI: rd_mux = {12'h000, codes_hi};
            `CCL_OFF_BRIDGE_LO: rd_mux = bridge_mask[31:0];
            `CCL_OFF_BRIDGE_HI: rd_mux = {16'h0000, bridge_mask[47:32]};
            `CCL_OFF_RATE_HZ: rd_mux = rate_hz;
            `CCL_OFF_LIMIT_SEL: rd_mux = {20'h00000, sel_src, 2'h0, sel_chan};
            `CCL_OFF_LIMIT_MIN: rd_mux = {{(32-VAL_W){lim_min[s_idx][VAL_W-1]}}, lim_min[s_idx]};
            `CCL_OFF_LIMIT_MAX: rd_mux = {{(32-VAL_W){lim_max[s_idx][VAL_W-1]}}, lim_max[s_idx]};
            `CCL_OFF_RESULT_SEL: rd_mux = {26'h0, res_chan};
            `CCL_OFF_RESULT_DETAIL:
                if (mode == `CCL_MODE_DETAIL && r_vld && res_chan < NUM_CHAN)
                    rd_mux = det_mem[r_addr];
            `CCL_OFF_SUMMARY0: rd_mux = {16'h0000, sum_pub[15:0]};
            `CCL_OFF_SUMMARY1: rd_mux = {16'h0000, sum_pub[31:16]};
            `CCL_OFF_SUMMARY2: rd_mux = {16'h0000, sum_pub[47:32]};
            `CCL_OFF_PAGE_STATUS: rd_mux = {16'h0, page_words, 6'h0, page_conf, check_valid};
            `CCL_OFF_INT_STATUS: rd_mux = {30'h0, int_status};
            `CCL_OFF_INT_CLEAR: rd_mux = 32'h0000_0000;
            `CCL_OFF_INT_ENABLE: rd_mux = {30'h0, int_enable};
            default: rd_err = 1'b1;
        endcase
    end

    // Register read data and error
    always @(posedge clk_sys) begin
        if (srst) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (clk_en && setup) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= rd_err;
        end
    end

    // ****************************************
    // Register writes
    // ****************************************
    always @(posedge clk_sys) begin
        if (srst) begin
            mode <= `CCL_RST_MODE;
            scan_source_count <= 4'h0;
            codes_lo <= 32'h0000_0000;
            codes_hi <= 20'h00000;
            bridge_mask <= 48'h0000_0000_0000;
            rate_hz <= `CCL_RST_RATE;
            sel_chan <= 6'h00;
            sel_src <= 4'h0;
            res_chan <= 6'h00;
            int_enable <= 2'h0;
        end else if (clk_en && wr_acc) begin
            case (paddr)
                `CCL_OFF_CTRL: mode <= pwdata[1:0];
                `CCL_OFF_SCAN_COUNT: scan_source_count <= pwdata[3:0];
                `CCL_OFF_SCAN_CODES_LO: codes_lo <= pwdata;
                `CCL_OFF_SCAN_CODES_HI: codes_hi <= pwdata[19:0];
                `CCL_OFF_BRIDGE_LO: bridge_mask[31:0] <= pwdata;
                `CCL_OFF_BRIDGE_HI: bridge_mask[47:32] <= pwdata[15:0];
                `CCL_OFF_RATE_HZ: rate_hz <= pwdata;
                `CCL_OFF_LIMIT_SEL: begin
                    sel_chan <= pwdata[5:0];
                    sel_src <= pwdata[`CCL_SEL_SRC_LSB +: 4];
                end
                `CCL_OFF_RESULT_SEL: res_chan <= pwdata[5:0];
                `CCL_OFF_INT_ENABLE: int_enable <= pwdata[1:0];
                default: ;
            endcase
        end
    end

    // Limit table writes, out of range selections ignored
    always @(posedge clk_sys) begin
        if (clk_en && wr_acc && sel_chan < NUM_CHAN && sel_src < NUM_SRC) begin
            if (paddr == `CCL_OFF_LIMIT_MIN)
                lim_min[s_idx] <= pwdata[VAL_W-1:0];
            if (paddr == `CCL_OFF_LIMIT_MAX)
                lim_max[s_idx] <= pwdata[VAL_W-1:0];
        end
    end

    // Detailed flag store into the filling bank
    always @(posedge clk_sys) begin
        if (clk_en && m_take && !page_start)
            det_mem[w_addr] <= w_new;
    end

    // ****************************************
    // Bank, summary and page control
    // ****************************************
    always @(posedge clk_sys) begin
        if (srst) begin
            bank <= 1'b0;
            vld0 <= 48'h0000_0000_0000;
            vld1 <= 48'h0000_0000_0000;
            sum_acc <= 48'h0000_0000_0000;
            sum_pub <= 48'h0000_0000_0000;
            alt <= 1'b0;
            page_conf <= 1'b0;
            page_words <= `CCL_PAGE_WORDS_BARE;
        end else if (clk_en) begin
            if (page_start) begin
                alt <= ~alt;
                page_conf <= attach;
                page_words <= attach ? `CCL_PAGE_WORDS_FULL : `CCL_PAGE_WORDS_BARE;
                if (attach) begin
                    // Publish the filled bank and start the other empty
                    bank <= ~bank;
                    sum_pub <= sum_acc;
                    sum_acc <= 48'h0000_0000_0000;
                    if (bank)
                        vld1 <= 48'h0000_0000_0000;
                    else
                        vld0 <= 48'h0000_0000_0000;
                end
            end else if (m_take) begin
                if (bank)
                    vld0[meas_chan] <= 1'b1;
                else
                    vld1[meas_chan] <= 1'b1;
                if (m_low || m_high)
                    sum_acc[meas_chan] <= 1'b1;
            end
        end
    end

    // ****************************************
    // Interrupt status, set wins over clear
    // ****************************************
    wire ev_page = page_start && attach;
    wire ev_exceed = ev_page && (sum_acc != 48'h0000_0000_0000);
    wire clr = wr_acc && (paddr == `CCL_OFF_INT_CLEAR);
    always @(posedge clk_sys) begin
        if (srst) begin
            int_status <= 2'h0;
        end else if (clk_en) begin
            int_status[`CCL_INT_PAGE_BIT] <= ev_page ||
                (int_status[`CCL_INT_PAGE_BIT] && !(clr && pwdata[`CCL_INT_PAGE_BIT]));
            int_status[`CCL_INT_EXCEED_BIT] <= ev_exceed ||
                (int_status[`CCL_INT_EXCEED_BIT] && !(clr && pwdata[`CCL_INT_EXCEED_BIT]));
        end
    end
    assign irq = |(int_status & int_enable);

endmodule // ccl_checker
`default_nettype wire

/* File: verilog/ccl_consts.vh */
// Constants for the confidence limit checker: register map, fields, resets, figures
`ifndef CCL_CONSTS_VH
`define CCL_CONSTS_VH
// Register byte offsets
`define CCL_OFF_CTRL 8'h00
`define CCL_OFF_SCAN_COUNT 8'h04
`define CCL_OFF_SCAN_CODES_LO 8'h08
`define CCL_OFF_SCAN_CODES_HI 8'h0C
`define CCL_OFF_BRIDGE_LO 8'h10
`define CCL_OFF_BRIDGE_HI 8'h14
`define CCL_OFF_RATE_HZ 8'h18
`define CCL_OFF_LIMIT_SEL 8'h1C
`define CCL_OFF_LIMIT_MIN 8'h20
`define CCL_OFF_LIMIT_MAX 8'h24
`define CCL_OFF_RESULT_SEL 8'h28
`define CCL_OFF_RESULT_DETAIL 8'h2C
`define CCL_OFF_SUMMARY0 8'h30
`define CCL_OFF_SUMMARY1 8'h34
`define CCL_OFF_SUMMARY2 8'h38
`define CCL_OFF_PAGE_STATUS 8'h3C
`define CCL_OFF_INT_STATUS 8'h40
`define CCL_OFF_INT_CLEAR 8'h44
`define CCL_OFF_INT_ENABLE 8'h48
// Reporting modes
`define CCL_MODE_DISABLE 2'h0
`define CCL_MODE_SUMMARY 2'h1
`define CCL_MODE_DETAIL 2'h2
// Field positions
`define CCL_SEL_SRC_LSB 8
`define CCL_MAX_FLAG_LSB 16
`define CCL_INT_PAGE_BIT 0
`define CCL_INT_EXCEED_BIT 1
// Reset values
`define CCL_RST_MODE 2'h0
`define CCL_RST_RATE 32'h0000_0000
// Page lengths in words
`define CCL_PAGE_WORDS_FULL 8'hF8
`define CCL_PAGE_WORDS_BARE 8'h18
// Rate figures in Hz
`define CCL_CHECK_RATE_LIMIT_HZ 32'd1000
`define CCL_CONF_RATE_MAX_HZ 32'd500
`endif
